/* File: rtl/tenbase_test_pkg.sv */
/*
 * Shared constants for the 10 Mb/s test pattern and self-test control block.
 * Assumes a 100 MHz system clock and 16-bit management registers.
 */
package tenbase_test_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [4:0] addr_tenbase_status_control = 5'h1A;
	localparam logic [4:0] addr_test_pattern_selftest_ext = 5'h1B;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int bit_long_tx_guard_off = 0;
	localparam int bit_sqe_test_off = 1;
	localparam int bit_polarity_inverted = 4;
	localparam int bit_pattern_choice_lo = 0;
	localparam int bit_pattern_idle_gap_sel = 2;
	localparam int bit_tenmeg_pattern_on = 4;
	localparam int bit_selftest_nonstop_tx = 5;
	localparam int bit_count_lo = 8;

	// ----------------------------------------------------------------
	// Reset and saturation values
	// ----------------------------------------------------------------
	localparam logic [15:0] reset_tenbase_status_control = 16'h0000;
	localparam logic [15:0] reset_test_pattern_selftest_ext = 16'h0000;
	localparam logic [7:0] reset_bad_nibble_count = 8'h00;
	localparam logic [7:0] max_bad_nibble_count = 8'hFF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int clk_period_ns = 10;
	localparam int gap_short_us = 10;
	localparam int gap_long_us = 15;
	localparam int gap_short_cycles = (gap_short_us * 1000) / clk_period_ns;
	localparam int gap_long_cycles = (gap_long_us * 1000) / clk_period_ns;
	localparam int burst_cycles = 64;
	localparam int gap_cnt_w = 16;

	// ----------------------------------------------------------------
	// Pattern choices
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		pat_data_eop_a = 2'h0,
		pat_data_eop_b = 2'h1,
		pat_link_pulse = 2'h2,
		pat_manchester_ones = 2'h3
	} pattern_choice_t;

endpackage : tenbase_test_pkg

/* File: rtl/bad_nibble_counter.sv */
/*
 * Saturating counter of errored nibbles seen during packet self-test.
 * Assumes error pulses and restart pulses are synchronous to clk_sys.
 */
`timescale 1ns/1ps
module bad_nibble_counter #(
	parameter int width = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Events
	input wire logic restart,
	input wire logic nibble_error,
	// Result
	output logic [width-1:0] count
);
	import tenbase_test_pkg::*;

	logic [width-1:0] next_count;

	always_comb begin
		next_count = count;
		if (restart) begin
			next_count = '0;
		end else if (nibble_error && count != {width{1'b1}}) begin
			next_count = count + {{(width-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	property p_saturate;
		@(posedge clk_sys) disable iff (reset)
		(count == {width{1'b1}} && !restart) |=> count == {width{1'b1}};
	endproperty
	a_saturate: assert property (p_saturate) else $error("count wrapped");

	property p_restart_clears;
		@(posedge clk_sys) disable iff (reset)
		restart |=> count == '0;
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("no clear");

	property p_counts;
		@(posedge clk_sys) disable iff (reset)
		(nibble_error && !restart && count != {width{1'b1}})
		|=> count == $past(count) + {{(width-1){1'b0}}, 1'b1};
	endproperty
	a_counts: assert property (p_counts) else $error("error not counted");

endmodule : bad_nibble_counter

/* File: rtl/pattern_gap_timer.sv */
/*
 * Sequences burst and idle gap for 10 Mb/s test patterns.
 * Assumes the enable is a level and the gap select may change at any time.
 */
`timescale 1ns/1ps
module pattern_gap_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic enable,
	input wire logic gap_long,
	// Status
	output logic in_burst,
	output logic burst_start
);
	import tenbase_test_pkg::*;

	localparam logic [gap_cnt_w-1:0] short_load = gap_cnt_w'(gap_short_cycles - 1);
	localparam logic [gap_cnt_w-1:0] long_load = gap_cnt_w'(gap_long_cycles - 1);
	localparam logic [gap_cnt_w-1:0] burst_load = gap_cnt_w'(burst_cycles - 1);

	logic [gap_cnt_w-1:0] timer;
	logic [gap_cnt_w-1:0] next_timer;
	logic next_in_burst;
	logic next_burst_start;

	always_comb begin
		next_timer = timer;
		next_in_burst = in_burst;
		next_burst_start = 1'b0;
		if (!enable) begin
			next_timer = '0;
			next_in_burst = 1'b0;
		end else if (timer != '0) begin
			next_timer = timer - gap_cnt_w'(1);
		end else if (in_burst) begin
			next_in_burst = 1'b0;
			next_timer = gap_long ? long_load : short_load;
		end else begin
			next_in_burst = 1'b1;
			next_burst_start = 1'b1;
			next_timer = burst_load;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timer <= '0;
			in_burst <= 1'b0;
			burst_start <= 1'b0;
		end else begin
			timer <= next_timer;
			in_burst <= next_in_burst;
			burst_start <= next_burst_start;
		end
	end

	property p_short_gap;
		@(posedge clk_sys) disable iff (reset)
		($fell(in_burst) && !gap_long && enable) ##1 (enable && !gap_long) [*8]
		|-> !in_burst;
	endproperty
	a_short_gap: assert property (p_short_gap) else $error("gap too short");

endmodule : pattern_gap_timer

/* File: rtl/tenbase_test_pattern_and_bist_ctrl.sv */
/*
 * 10 Mb/s test pattern and packet self-test control registers and sequencing.
 * Assumes a plain register port with one-cycle strobes and read data one cycle later,
 * and link speed, duplex and self-test status supplied by the rest of the PHY.
 */
`timescale 1ns/1ps
module tenbase_test_pattern_and_bist_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Link state from the PHY
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic polarity_inverted,
	// Self-test from the PHY
	input wire logic selftest_start,
	input wire logic selftest_restart,
	input wire logic nibble_error,
	// Controls to the 10 Mb/s transmitter
	output logic sqe_test_enable,
	output logic long_tx_guard_enable,
	output logic selftest_nonstop_active,
	output logic pattern_active,
	output logic pattern_burst_start,
	output logic [1:0] pattern_choice,
	output logic tone_10mhz,
	output logic link_pulse_mode,
	output logic end_of_packet_variant_b
);
	import tenbase_test_pkg::*;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic sqe_test_off;
	logic long_tx_guard_off;
	logic selftest_nonstop_tx;
	logic tenmeg_pattern_on;
	logic pattern_idle_gap_sel;
	logic [1:0] pattern_sel;
	logic polarity_latch;
	logic next_sqe_test_off;
	logic next_long_tx_guard_off;
	logic next_selftest_nonstop_tx;
	logic next_tenmeg_pattern_on;
	logic next_pattern_idle_gap_sel;
	logic [1:0] next_pattern_sel;
	logic next_polarity_latch;
	logic [7:0] selftest_bad_nibble_count;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
		return a == target;
	endfunction : hit

	always_comb begin
		next_sqe_test_off = sqe_test_off;
		next_long_tx_guard_off = long_tx_guard_off;
		next_selftest_nonstop_tx = selftest_nonstop_tx;
		next_tenmeg_pattern_on = tenmeg_pattern_on;
		next_pattern_idle_gap_sel = pattern_idle_gap_sel;
		next_pattern_sel = pattern_sel;
		next_polarity_latch = polarity_latch;
		if (reg_write && hit(reg_addr, addr_tenbase_status_control)) begin
			next_sqe_test_off = reg_wdata[bit_sqe_test_off];
			next_long_tx_guard_off = reg_wdata[bit_long_tx_guard_off];
		end
		if (reg_write && hit(reg_addr, addr_test_pattern_selftest_ext)) begin
			next_selftest_nonstop_tx = reg_wdata[bit_selftest_nonstop_tx];
			next_tenmeg_pattern_on = reg_wdata[bit_tenmeg_pattern_on];
			next_pattern_idle_gap_sel = reg_wdata[bit_pattern_idle_gap_sel];
			next_pattern_sel = reg_wdata[bit_pattern_choice_lo +: 2];
		end
		// A read clears the latch, but a new detection in that cycle wins.
		if (reg_read && hit(reg_addr, addr_tenbase_status_control)) begin
			next_polarity_latch = 1'b0;
		end
		if (polarity_inverted) begin
			next_polarity_latch = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sqe_test_off <= reset_tenbase_status_control[bit_sqe_test_off];
			long_tx_guard_off <= reset_tenbase_status_control[bit_long_tx_guard_off];
			selftest_nonstop_tx <= reset_test_pattern_selftest_ext[bit_selftest_nonstop_tx];
			tenmeg_pattern_on <= reset_test_pattern_selftest_ext[bit_tenmeg_pattern_on];
			pattern_idle_gap_sel <= reset_test_pattern_selftest_ext[bit_pattern_idle_gap_sel];
			pattern_sel <= reset_test_pattern_selftest_ext[bit_pattern_choice_lo +: 2];
			polarity_latch <= 1'b0;
		end else begin
			sqe_test_off <= next_sqe_test_off;
			long_tx_guard_off <= next_long_tx_guard_off;
			selftest_nonstop_tx <= next_selftest_nonstop_tx;
			tenmeg_pattern_on <= next_tenmeg_pattern_on;
			pattern_idle_gap_sel <= next_pattern_idle_gap_sel;
			pattern_sel <= next_pattern_sel;
			polarity_latch <= next_polarity_latch;
		end
	end

	// ----------------------------------------------------------------
	// Self-test error counter and pattern gap timer
	// ----------------------------------------------------------------
	logic gap_in_burst;
	logic gap_burst_start;

	bad_nibble_counter #(
		.width(8)
	) u_counter (
		.clk_sys(clk_sys),
		.reset(reset),
		.restart(selftest_restart),
		.nibble_error(nibble_error),
		.count(selftest_bad_nibble_count)
	);

	pattern_gap_timer u_gap (
		.clk_sys(clk_sys),
		.reset(reset),
		.enable(tenmeg_pattern_on),
		.gap_long(pattern_idle_gap_sel),
		.in_burst(gap_in_burst),
		.burst_start(gap_burst_start)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [15:0] next_reg_rdata;

	always_comb begin
		next_reg_rdata = 16'h0000;
		if (reg_read && hit(reg_addr, addr_tenbase_status_control)) begin
			next_reg_rdata[bit_sqe_test_off] = sqe_test_off;
			next_reg_rdata[bit_long_tx_guard_off] = long_tx_guard_off;
			next_reg_rdata[bit_polarity_inverted] = polarity_latch | polarity_inverted;
		end else if (reg_read && hit(reg_addr, addr_test_pattern_selftest_ext)) begin
			next_reg_rdata[bit_count_lo +: 8] = selftest_bad_nibble_count;
			next_reg_rdata[bit_selftest_nonstop_tx] = selftest_nonstop_tx;
			next_reg_rdata[bit_tenmeg_pattern_on] = tenmeg_pattern_on;
			next_reg_rdata[bit_pattern_idle_gap_sel] = pattern_idle_gap_sel;
			next_reg_rdata[bit_pattern_choice_lo +: 2] = pattern_sel;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter controls
	// ----------------------------------------------------------------
	logic next_sqe_test_enable;
	logic next_long_tx_guard_enable;
	logic next_nonstop_active;
	logic next_pattern_active;
	logic next_tone;
	logic next_link_pulse;
	logic next_eop_b;

	always_comb begin
		// Heartbeat only survives in half-duplex 10 Mb/s.
		next_sqe_test_enable = !sqe_test_off && !speed_100 && !full_duplex;
		next_long_tx_guard_enable = !long_tx_guard_off && !speed_100;
		next_nonstop_active = selftest_nonstop_tx && selftest_start;
		next_pattern_active = tenmeg_pattern_on && gap_in_burst;
		next_tone = tenmeg_pattern_on && pattern_sel == pat_manchester_ones;
		next_link_pulse = tenmeg_pattern_on && pattern_sel == pat_link_pulse;
		next_eop_b = tenmeg_pattern_on && pattern_sel == pat_data_eop_b;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
			sqe_test_enable <= 1'b0;
			long_tx_guard_enable <= 1'b0;
			selftest_nonstop_active <= 1'b0;
			pattern_active <= 1'b0;
			pattern_burst_start <= 1'b0;
			pattern_choice <= 2'h0;
			tone_10mhz <= 1'b0;
			link_pulse_mode <= 1'b0;
			end_of_packet_variant_b <= 1'b0;
		end else begin
			reg_rdata <= next_reg_rdata;
			sqe_test_enable <= next_sqe_test_enable;
			long_tx_guard_enable <= next_long_tx_guard_enable;
			selftest_nonstop_active <= next_nonstop_active;
			pattern_active <= next_pattern_active;
			pattern_burst_start <= gap_burst_start;
			pattern_choice <= pattern_sel;
			tone_10mhz <= next_tone;
			link_pulse_mode <= next_link_pulse;
			end_of_packet_variant_b <= next_eop_b;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_sqe_fast_off;
		@(posedge clk_sys) disable iff (reset)
		(speed_100 || full_duplex) |=> !sqe_test_enable;
	endproperty
	a_sqe_fast_off: assert property (p_sqe_fast_off) else $error("heartbeat on");

	property p_sqe_half;
		@(posedge clk_sys) disable iff (reset)
		(!speed_100 && !full_duplex) |=> sqe_test_enable == !$past(sqe_test_off);
	endproperty
	a_sqe_half: assert property (p_sqe_half) else $error("heartbeat wrong");

	property p_guard;
		@(posedge clk_sys) disable iff (reset)
		(reg_write && reg_addr == addr_tenbase_status_control && reg_wdata[0] && !speed_100)
		|=> ##1 !long_tx_guard_enable;
	endproperty
	a_guard: assert property (p_guard) else $error("jabber not off");

	property p_nonstop_needs_start;
		@(posedge clk_sys) disable iff (reset)
		!selftest_start |=> !selftest_nonstop_active;
	endproperty
	a_nonstop_needs_start: assert property (p_nonstop_needs_start) else $error("nonstop alone");

	property p_nonstop_on;
		@(posedge clk_sys) disable iff (reset)
		(selftest_start && selftest_nonstop_tx) |=> selftest_nonstop_active;
	endproperty
	a_nonstop_on: assert property (p_nonstop_on) else $error("nonstop missing");

	property p_pattern_off;
		@(posedge clk_sys) disable iff (reset)
		!tenmeg_pattern_on |=> !pattern_active && !tone_10mhz && !link_pulse_mode;
	endproperty
	a_pattern_off: assert property (p_pattern_off) else $error("pattern while off");

	property p_tone;
		@(posedge clk_sys) disable iff (reset)
		(tenmeg_pattern_on && pattern_sel == 2'h3) |=> tone_10mhz && !link_pulse_mode;
	endproperty
	a_tone: assert property (p_tone) else $error("tone missing");

	property p_polarity_held;
		@(posedge clk_sys) disable iff (reset)
		(polarity_inverted ##1 !(reg_read && reg_addr == addr_tenbase_status_control))
		|=> polarity_latch;
	endproperty
	a_polarity_held: assert property (p_polarity_held) else $error("polarity lost");

	property p_count_read;
		@(posedge clk_sys) disable iff (reset)
		(reg_read && reg_addr == addr_test_pattern_selftest_ext)
		|=> reg_rdata[15:8] == $past(selftest_bad_nibble_count) && reg_rdata[7:6] == 2'h0;
	endproperty
	a_count_read: assert property (p_count_read) else $error("count readback");

	// The jabber guard must come back as soon as the bit is cleared at 10 Mb/s.
	property p_guard_on;
		@(posedge clk_sys) disable iff (reset)
		(!long_tx_guard_off && !speed_100) |=> long_tx_guard_enable;
	endproperty
	a_guard_on: assert property (p_guard_on) else $error("jabber not on");

	property p_link_pulse;
		@(posedge clk_sys) disable iff (reset)
		(tenmeg_pattern_on && pattern_sel == pat_link_pulse) |=> link_pulse_mode && !tone_10mhz;
	endproperty
	a_link_pulse: assert property (p_link_pulse) else $error("link pulses missing");

	property p_eop_b;
		@(posedge clk_sys) disable iff (reset)
		(tenmeg_pattern_on && pattern_sel == pat_data_eop_b)
		|=> end_of_packet_variant_b && !link_pulse_mode && !tone_10mhz;
	endproperty
	a_eop_b: assert property (p_eop_b) else $error("end variant b missing");

	// A status read with no live inversion must leave the latch clear.
	property p_polarity_clear;
		@(posedge clk_sys) disable iff (reset)
		(reg_read && reg_addr == addr_tenbase_status_control && !polarity_inverted)
		|=> !polarity_latch;
	endproperty
	a_polarity_clear: assert property (p_polarity_clear) else $error("polarity kept");

endmodule : tenbase_test_pattern_and_bist_ctrl

/* File: test/phy_side_model.sv */
/*
 * Model of the PHY datapath beside the test controls: it emits errored-nibble pulses and
 * self-test restart pulses on command from the bench.
 * Assumes commands are one-cycle pulses synchronous to clk_sys.
 */
`timescale 1ns/1ps
module phy_side_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Commands from the bench
	input wire logic [15:0] err_total,
	input wire logic [3:0] err_space,
	input wire logic err_go,
	input wire logic restart_go,
	// Toward the block
	output logic nibble_error,
	output logic selftest_restart,
	output logic err_busy
);
	logic [15:0] left;
	logic [3:0] wait_cnt;

	// ----------------------------------------------------------------
	// Error and restart pulses
	// ----------------------------------------------------------------
	// A nonzero spacing gives the slow case, zero gives one error every cycle.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			left <= 16'h0000;
			wait_cnt <= 4'h0;
			nibble_error <= 1'b0;
			selftest_restart <= 1'b0;
		end else begin
			selftest_restart <= restart_go;
			nibble_error <= 1'b0;
			if (err_go) begin
				left <= err_total;
				wait_cnt <= 4'h0;
			end else if (left != 16'h0000) begin
				if (wait_cnt == 4'h0) begin
					nibble_error <= 1'b1;
					left <= left - 16'h0001;
					wait_cnt <= err_space;
				end else begin
					wait_cnt <= wait_cnt - 4'h1;
				end
			end
		end
	end

	assign err_busy = err_go || (left != 16'h0000);
endmodule : phy_side_model

/* File: test/test_tenbase_test_pattern_and_bist_ctrl.sv */
/*
 * Self-checking bench for the 10 Mb/s test pattern and self-test control block.
 * Assumes the package constants and the two-cycle control latency of the block.
 */
`timescale 1ns/1ps
module test_tenbase_test_pattern_and_bist_ctrl;
	import tenbase_test_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic speed_100 = 1'b0;
	logic full_duplex = 1'b0;
	logic polarity_inverted = 1'b0;
	logic selftest_start = 1'b0;
	logic selftest_restart, nibble_error, err_busy;
	logic sqe_test_enable, long_tx_guard_enable, selftest_nonstop_active, pattern_active;
	logic pattern_burst_start, tone_10mhz, link_pulse_mode, end_of_packet_variant_b;
	logic [1:0] pattern_choice;
	logic [15:0] err_total = 16'h0000;
	logic [3:0] err_space = 4'h0;
	logic err_go = 1'b0;
	logic restart_go = 1'b0;
	logic rd_pending = 1'b0;
	logic [15:0] expect_q[$];
	logic [15:0] lfsr = 16'h0009;
	logic [15:0] val;
	logic [7:0] count_exp = 8'h00;
	int n_fail = 0;
	int comparisons = 0;
	int cnt;
	int n2;

	always #5 clk_sys = ~clk_sys;

	tenbase_test_pattern_and_bist_ctrl uut (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .speed_100(speed_100),
		.full_duplex(full_duplex), .polarity_inverted(polarity_inverted),
		.selftest_start(selftest_start), .selftest_restart(selftest_restart),
		.nibble_error(nibble_error), .sqe_test_enable(sqe_test_enable),
		.long_tx_guard_enable(long_tx_guard_enable),
		.selftest_nonstop_active(selftest_nonstop_active), .pattern_active(pattern_active),
		.pattern_burst_start(pattern_burst_start), .pattern_choice(pattern_choice),
		.tone_10mhz(tone_10mhz), .link_pulse_mode(link_pulse_mode),
		.end_of_packet_variant_b(end_of_packet_variant_b));

	phy_side_model partner (.clk_sys(clk_sys), .reset(reset), .err_total(err_total),
		.err_space(err_space), .err_go(err_go), .restart_go(restart_go),
		.nibble_error(nibble_error), .selftest_restart(selftest_restart), .err_busy(err_busy));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic conclude();
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic compare_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : compare_word

	task automatic compare_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : compare_bit

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		@(posedge clk_sys);
	endtask : reg_wr

	task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		expect_q.push_back(exp);
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(posedge clk_sys);
	endtask : reg_rd

	// Control outputs lag a write by two edges; a third edge leaves margin.
	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask : settle

	task automatic run_errors(input logic [15:0] n, input logic [3:0] space);
		err_total <= n;
		err_space <= space;
		err_go <= 1'b1;
		@(posedge clk_sys);
		err_go <= 1'b0;
		cnt = 0;
		do begin
			@(posedge clk_sys);
			cnt++;
		end while (err_busy !== 1'b0 && cnt < 10000);
		if (cnt >= 10000) begin
			n_fail++;
			$display("unexpected err_busy: expected 0 seen 1");
			conclude();
		end
		settle();
		count_exp = (count_exp + n > 255) ? 8'hFF : 8'(count_exp + n);
	endtask : run_errors

	task automatic restart();
		restart_go <= 1'b1;
		@(posedge clk_sys);
		restart_go <= 1'b0;
		settle();
		count_exp = 8'h00;
	endtask : restart

	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pattern_burst_start !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			n_fail++;
			$display("unexpected pattern_burst_start: expected 1 seen 0");
			conclude();
		end
	endtask : wait_pulse

	task automatic check_period(input int gap);
		wait_pulse(n2);
		wait_pulse(n2);
		cnt = 0;
		while (pattern_active === 1'b1 && cnt < 4000) begin
			cnt++;
			@(posedge clk_sys);
		end
		compare_word("burst length", 16'(burst_cycles), 16'(cnt));
		wait_pulse(n2);
		compare_word("burst period", 16'(burst_cycles + gap), 16'(cnt + n2));
	endtask : check_period

	// ----------------------------------------------------------------
	// Read data monitor
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rd_pending) begin
			if (expect_q.size() == 0) begin
				n_fail++;
				$display("unexpected reg_rdata: expected none seen %h", reg_rdata);
			end else begin
				compare_word("reg_rdata", expect_q.pop_front(), reg_rdata);
			end
		end
		rd_pending <= reg_read;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		reg_rd(addr_tenbase_status_control, 16'h0000);
		reg_rd(addr_test_pattern_selftest_ext, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			speed_100 <= i[2];
			full_duplex <= i[3];
			reg_wr(addr_tenbase_status_control, {14'h0000, i[1:0]});
			settle();
			compare_bit("sqe_test_enable", ~i[1] & ~i[2] & ~i[3], sqe_test_enable);
			compare_bit("long_tx_guard_enable", ~i[0] & ~i[2], long_tx_guard_enable);
		end
		speed_100 <= 1'b0;
		full_duplex <= 1'b0;
		reg_wr(5'h05, 16'hFFFF);
		reg_rd(5'h05, 16'h0000);
		reg_rd(addr_tenbase_status_control, 16'h0003);
		reg_rd(addr_test_pattern_selftest_ext, 16'h0000);
		// Every choice with and without enable; random bits land on the read-only count bits and the nonstop self-test bit.
		for (int i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			val = (lfsr & 16'hFF20) | {11'h000, i[2], 1'b0, i[3], i[1:0]};
			reg_wr(addr_test_pattern_selftest_ext, val);
			reg_rd(addr_test_pattern_selftest_ext, val & 16'h0037);
			settle();
			compare_word("pattern_choice", {14'h0000, val[1:0]}, {14'h0000, pattern_choice});
			compare_bit("tone_10mhz", val[4] & (val[1:0] == 2'h3), tone_10mhz);
			compare_bit("link_pulse_mode", val[4] & (val[1:0] == 2'h2), link_pulse_mode);
			compare_bit("end_of_packet_variant_b", val[4] & (val[1:0] == 2'h1),
				end_of_packet_variant_b);
			compare_bit("selftest_nonstop_active", 1'b0, selftest_nonstop_active);
		end
		reg_wr(addr_tenbase_status_control, 16'h0001);
		reg_wr(addr_test_pattern_selftest_ext, 16'h0020);
		settle();
		compare_bit("selftest_nonstop_active", 1'b0, selftest_nonstop_active);
		selftest_start <= 1'b1;
		settle();
		compare_bit("selftest_nonstop_active", 1'b1, selftest_nonstop_active);
		restart();
		run_errors(16'd5, 4'h2);
		reg_rd(addr_test_pattern_selftest_ext, {count_exp, 8'h20});
		reg_wr(addr_test_pattern_selftest_ext, 16'hFF20);
		reg_rd(addr_test_pattern_selftest_ext, {count_exp, 8'h20});
		restart();
		reg_rd(addr_test_pattern_selftest_ext, 16'h0020);
		run_errors(16'd300, 4'h0);
		reg_rd(addr_test_pattern_selftest_ext, {max_bad_nibble_count, 8'h20});
		run_errors(16'd3, 4'h1);
		reg_rd(addr_test_pattern_selftest_ext, {max_bad_nibble_count, 8'h20});
		selftest_start <= 1'b0;
		polarity_inverted <= 1'b1;
		@(posedge clk_sys);
		polarity_inverted <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reg_rd(addr_tenbase_status_control, 16'h0011);
		reg_rd(addr_tenbase_status_control, 16'h0001);
		reg_wr(addr_test_pattern_selftest_ext, 16'h0010);
		check_period(gap_short_cycles);
		reg_wr(addr_test_pattern_selftest_ext, 16'h0014);
		check_period(gap_long_cycles);
		reset <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		compare_bit("pattern_active", 1'b0, pattern_active);
		reg_rd(addr_test_pattern_selftest_ext, 16'h0000);
		reg_rd(addr_tenbase_status_control, 16'h0000);
		settle();
		compare_bit("long_tx_guard_enable", 1'b1, long_tx_guard_enable);
		conclude();
	end
endmodule : test_tenbase_test_pattern_and_bist_ctrl
